// ===== verilog/ew_pkg.sv
// ************************************************************
// Constants and types shared by the serial EEPROM front end.
// ************************************************************
package ew_pkg;

  // ************************************************************
  // Memory geometry.
  // ************************************************************
  localparam int BYTE_W    = 8;
  localparam int WORD_W    = 16;
  localparam int MEM_BYTES = 512;
  localparam int BYTE_AW   = 9;
  localparam int X8_AW     = 9;
  localparam int X16_AW    = 8;
  localparam int CNT_W     = 5;

  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;

  // ************************************************************
  // Instruction encoding after the start bit.
  // ************************************************************
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] SUB_EWDS   = 2'h0;
  localparam logic [1:0] SUB_EWEN   = 2'h3;

  // ************************************************************
  // Self-timed write cycle.
  // ************************************************************
  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_MHZ       = 250;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W       = 21;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_OP,
    LS_ADDR,
    LS_DATA,
    LS_READ,
    LS_DONE
  } ew_link_state_t;

  // Levels passed from the link domain to the system domain.
  typedef struct packed {
    logic active;
    logic rd_act;
    logic rd_bit;
  } ew_link_status_t;

  typedef struct packed {
    logic               en;
    logic               wide;
    logic [BYTE_AW-1:0] addr;
    logic [WORD_W-1:0]  data;
  } ew_mem_wr_t;

endpackage

// ===== verilog/ew_sync.sv
`timescale 1ns/100ps
// ************************************************************
// Two-stage synchroniser, one per bit, cleared by reset.
// ************************************************************
module ew_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (reset) begin
          stage1[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          dout[i]   <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // ew_sync

// ===== verilog/ew_mem.sv
`timescale 1ns/100ps
// ************************************************************
// Byte array in flip-flops; a wide write fills a byte pair.
// ************************************************************
module ew_mem
  import ew_pkg::*;
(
  // Clock
  input  wire logic               clock,
  // Write port
  input  wire ew_mem_wr_t         wr,
  // Read port
  input  wire logic [BYTE_AW-1:0] rd_addr,
  output logic      [BYTE_W-1:0]  rd_lo,
  output logic      [BYTE_W-1:0]  rd_hi
);

  logic [BYTE_W-1:0] mem [MEM_BYTES];

  genvar i;
  generate
    for (i = 0; i < MEM_BYTES; i++) begin : g_byte
      localparam logic [BYTE_AW-1:0] IDX = BYTE_AW'(i);
      always_ff @(posedge clock) begin
        if (wr.en && wr.addr == IDX) begin
          mem[i] <= wr.data[BYTE_W-1:0];
        end else if (wr.en && wr.wide && (wr.addr | 9'h001) == IDX) begin
          mem[i] <= wr.data[WORD_W-1:BYTE_W];
        end
      end
    end
  endgenerate

  assign rd_lo = mem[rd_addr];
  assign rd_hi = mem[rd_addr | 9'h001];

endmodule // ew_mem

// ===== verilog/ew_top.sv
`timescale 1ns/100ps
module ew_top
  import ew_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // System clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Serial link
  input  wire logic serial_clock,
  input  wire logic device_select,
  input  wire logic serial_in,
  input  wire logic word_width_select,
  // Serial output with its enable
  output logic      serial_out,
  output logic      serial_out_oe
);

  // ************************************************************
  // Link domain declarations.
  // ************************************************************
  logic                link_clr;
  ew_link_state_t      state;
  ew_link_state_t      next_state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  logic [1:0]          op;
  logic [1:0]          next_op;
  logic [BYTE_AW-1:0]  addr;
  logic [BYTE_AW-1:0]  next_addr;
  logic [WORD_W-1:0]   data;
  logic [WORD_W-1:0]   next_data;
  logic [WORD_W-1:0]   rd_sh;
  logic [WORD_W-1:0]   next_rd_sh;
  logic                rd_bit;
  logic                next_rd_bit;
  logic                ewen;
  logic                next_ewen;
  logic                wr_tgl;
  logic                next_wr_tgl;
  logic                org_l;
  logic                busy_l;
  logic [BYTE_AW-1:0]  shifted_addr;
  logic [BYTE_AW-1:0]  addr_inc;
  logic [CNT_W-1:0]    addr_last;
  logic [CNT_W-1:0]    data_last;
  logic [1:0]          sub_op;
  logic                wr_ok;
  logic [BYTE_AW-1:0]  mem_rd_addr;
  logic [BYTE_W-1:0]   mem_lo;
  logic [BYTE_W-1:0]   mem_hi;
  logic [WORD_W-1:0]   mem_word;
  ew_mem_wr_t          mem_wr;
  ew_link_status_t     lstat;

  // ************************************************************
  // System domain declarations.
  // ************************************************************
  logic                sel_s;
  ew_link_status_t     lstat_s;
  logic                tgl_s;
  logic                tgl_prev;
  logic                next_tgl_prev;
  logic                busy;
  logic                next_busy;
  logic [TIMER_W-1:0]  timer;
  logic [TIMER_W-1:0]  next_timer;
  logic                armed;
  logic                next_armed;
  logic                seen_low;
  logic                next_seen_low;
  logic                next_serial_out;
  logic                next_serial_out_oe;
  logic                wr_event;
  logic                show_status;

  // Word address to the byte address of its low byte.
  function automatic logic [BYTE_AW-1:0] to_byte(input logic [BYTE_AW-1:0] a,
                                                 input logic              wide);
    to_byte = wide ? {a[X16_AW-1:0], 1'b0} : a;
  endfunction

  // ************************************************************
  // Crossings into the link domain.
  // ************************************************************
  ew_sync #(
    .W (2)
  ) u_sync_link (
    .clock (serial_clock),
    .reset (reset),
    .din   ({word_width_select, busy}),
    .dout  ({org_l, busy_l})
  );

  // ************************************************************
  // Storage, clocked by the link.
  // ************************************************************
  ew_mem u_mem (
    .clock   (serial_clock),
    .wr      (mem_wr),
    .rd_addr (mem_rd_addr),
    .rd_lo   (mem_lo),
    .rd_hi   (mem_hi)
  );

  // ************************************************************
  // Link-domain command decoder.
  // ************************************************************
  // A low select clears the decoder at once, so a stopped link clock
  // cannot leave a half-received instruction behind.
  assign link_clr = reset | ~device_select;

  always_comb begin
    // The strap is read here on every instruction; a floating pin is
    // expected to sit high through the pad pull-up.
    addr_last    = org_l ? CNT_W'(X16_AW - 1) : CNT_W'(X8_AW - 1);
    data_last    = org_l ? CNT_W'(WORD_W - 1) : CNT_W'(BYTE_W - 1);
    shifted_addr = {addr[BYTE_AW-2:0], serial_in};
    addr_inc     = addr + 9'h001;
    sub_op       = org_l ? shifted_addr[X16_AW-1 -: 2] : shifted_addr[X8_AW-1 -: 2];
    wr_ok        = ewen & ~busy_l;
    mem_rd_addr  = to_byte((state == LS_ADDR) ? shifted_addr : addr_inc, org_l);
    mem_word     = org_l ? {mem_hi, mem_lo} : {mem_lo, 8'h00};
    next_state   = state;
    next_cnt     = cnt;
    next_op      = op;
    next_addr    = addr;
    next_data    = data;
    next_rd_sh   = rd_sh;
    next_rd_bit  = rd_bit;
    next_ewen    = ewen;
    next_wr_tgl  = wr_tgl;
    mem_wr       = '0;
    unique case (state)
      LS_IDLE: begin
        if (serial_in) begin
          next_state = LS_OP;
          next_cnt   = '0;
        end
      end
      LS_OP: begin
        next_op  = {op[0], serial_in};
        next_cnt = cnt + 5'h01;
        if (cnt == 5'h01) begin
          next_state = LS_ADDR;
          next_cnt   = '0;
        end
      end
      LS_ADDR: begin
        next_addr = shifted_addr;
        next_cnt  = cnt + 5'h01;
        if (cnt == addr_last) begin
          next_cnt = '0;
          unique case (op)
            OP_READ: begin
              // A leading zero goes out first, then the word from its MSB.
              next_state  = LS_READ;
              next_rd_sh  = mem_word;
              next_rd_bit = 1'b0;
            end
            OP_WRITE: begin
              next_state = LS_DATA;
            end
            OP_ERASE: begin
              next_state = LS_DONE;
              if (wr_ok) begin
                mem_wr.en   = 1'b1;
                mem_wr.wide = org_l;
                mem_wr.addr = to_byte(shifted_addr, org_l);
                mem_wr.data = {ERASED_BYTE, ERASED_BYTE};
                next_wr_tgl = ~wr_tgl;
              end
            end
            OP_SPECIAL: begin
              next_state = LS_DONE;
              if (sub_op == SUB_EWEN) begin
                next_ewen = 1'b1;
              end else if (sub_op == SUB_EWDS) begin
                next_ewen = 1'b0;
              end
            end
          endcase
        end
      end
      LS_DATA: begin
        next_data = {data[WORD_W-2:0], serial_in};
        next_cnt  = cnt + 5'h01;
        if (cnt == data_last) begin
          next_state = LS_DONE;
          // The word overwrites old contents directly, no erase first.
          if (wr_ok) begin
            mem_wr.en   = 1'b1;
            mem_wr.wide = org_l;
            mem_wr.addr = to_byte(addr, org_l);
            mem_wr.data = {data[WORD_W-2:0], serial_in};
            next_wr_tgl = ~wr_tgl;
          end
        end
      end
      LS_READ: begin
        next_rd_bit = rd_sh[WORD_W-1];
        next_rd_sh  = {rd_sh[WORD_W-2:0], 1'b0};
        next_cnt    = cnt + 5'h01;
        if (cnt == data_last) begin
          // Sequential read: the next word follows without a gap.
          next_cnt   = '0;
          next_addr  = addr_inc;
          next_rd_sh = mem_word;
        end
      end
      LS_DONE: begin
      end
    endcase
    lstat.active = (state != LS_IDLE);
    lstat.rd_act = (state == LS_READ);
    lstat.rd_bit = rd_bit;
  end

  always_ff @(posedge serial_clock or posedge link_clr) begin
    if (link_clr) begin
      state  <= LS_IDLE;
      cnt    <= '0;
      op     <= '0;
      addr   <= '0;
      data   <= '0;
      rd_sh  <= '0;
      rd_bit <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      op     <= next_op;
      addr   <= next_addr;
      data   <= next_data;
      rd_sh  <= next_rd_sh;
      rd_bit <= next_rd_bit;
    end
  end

  // The enable state and the write event survive a deselect.
  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      ewen   <= 1'b0;
      wr_tgl <= 1'b0;
    end else begin
      ewen   <= next_ewen;
      wr_tgl <= next_wr_tgl;
    end
  end

  // ************************************************************
  // Crossings into the system domain.
  // ************************************************************
  ew_sync #(
    .W (5)
  ) u_sync_sys (
    .clock (clock),
    .reset (reset),
    .din   ({device_select, lstat, wr_tgl}),
    .dout  ({sel_s, lstat_s, tgl_s})
  );

  // ************************************************************
  // Write timer, status arming and output drive.
  // ************************************************************
  always_comb begin
    wr_event      = (tgl_s != tgl_prev);
    next_tgl_prev = tgl_s;
    next_busy     = busy;
    next_timer    = timer;
    if (wr_event) begin
      next_busy  = 1'b1;
      next_timer = TIMER_W'(WRITE_CYCLES_P - 1);
    end else if (busy) begin
      if (timer == '0) begin
        next_busy = 1'b0;
      end else begin
        next_timer = timer - 21'h000001;
      end
    end
    // Status is shown only after a deselect that follows a write start,
    // until the host begins a new instruction. A new write wins.
    next_armed    = armed;
    next_seen_low = seen_low;
    if (sel_s && lstat_s.active && seen_low) begin
      next_armed    = 1'b0;
      next_seen_low = 1'b0;
    end
    if (!sel_s && armed) begin
      next_seen_low = 1'b1;
    end
    if (wr_event) begin
      next_armed    = 1'b1;
      next_seen_low = 1'b0;
    end
    show_status        = sel_s & armed & seen_low & ~lstat_s.active;
    next_serial_out_oe = sel_s & (lstat_s.rd_act | show_status);
    if (!next_serial_out_oe) begin
      next_serial_out = 1'b0;
    end else if (lstat_s.rd_act) begin
      next_serial_out = lstat_s.rd_bit;
    end else begin
      next_serial_out = ~busy;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tgl_prev      <= 1'b0;
      busy          <= 1'b0;
      timer         <= '0;
      armed         <= 1'b0;
      seen_low      <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      tgl_prev      <= next_tgl_prev;
      busy          <= next_busy;
      timer         <= next_timer;
      armed         <= next_armed;
      seen_low      <= next_seen_low;
      serial_out    <= next_serial_out;
      serial_out_oe <= next_serial_out_oe;
    end
  end

endmodule // ew_top

// ===== verif/ew_top_monitor.sv
`timescale 1ns/100ps
// ************************************************************
// Pin checker for the serial EEPROM front end.
// ************************************************************
module ew_top_monitor
  import ew_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Link and strap
  input  wire logic serial_clock,
  input  wire logic device_select,
  input  wire logic serial_in,
  input  wire logic word_width_select,
  // Output pin
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic       sk_d;
  logic       cs_d;
  logic [4:0] hist;
  int         quiet;
  logic       next_sk_d;
  logic       next_cs_d;
  logic [4:0] next_hist;
  int         next_quiet;

  // Link events of the last five cycles, and cycles of low status with no link event.
  always_comb begin
    if (reset) begin
      next_sk_d  = 1'b0;
      next_cs_d  = 1'b0;
      next_hist  = 5'h00;
      next_quiet = 0;
    end else begin
      next_sk_d  = serial_clock;
      next_cs_d  = device_select;
      next_hist  = {hist[3:0], (serial_clock & ~sk_d) | (device_select & ~cs_d)};
      next_quiet = (serial_out_oe && !serial_out && hist == 5'h00) ? quiet + 1 : 0;
    end
  end

  always_ff @(posedge clock) begin
    sk_d  <= next_sk_d;
    cs_d  <= next_cs_d;
    hist  <= next_hist;
    quiet <= next_quiet;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_deselected;
    !device_select [*6];
  endsequence
  sequence s_oe_up;
    $rose(serial_out_oe);
  endsequence

  property p_idle_release;
    s_deselected |-> !serial_out_oe;
  endproperty
  property p_idle_low;
    !serial_out_oe |-> !serial_out;
  endproperty
  property p_oe_needs_select;
    s_oe_up |-> device_select && $past(device_select, 2);
  endproperty
  property p_oe_cause;
    s_oe_up |-> hist != 5'h00;
  endproperty
  property p_oe_hold;
    $fell(serial_out_oe) |-> hist != 5'h00 || (!$past(device_select)
      && !$past(device_select, 2) && !$past(device_select, 3));
  endproperty
  property p_fall_needs_link;
    $fell(serial_out) && serial_out_oe && $past(serial_out_oe) && device_select
      && $past(device_select, 3) |-> hist != 5'h00;
  endproperty
  property p_busy_bound;
    quiet <= WRITE_CYCLES_P + 8;
  endproperty
  property p_deselect_release;
    $fell(device_select) |-> ##4 !serial_out_oe;
  endproperty

  a_idle_release: assert property (p_idle_release) else $error("driven while deselected");
  a_idle_low: assert property (p_idle_low) else $error("output high while released");
  a_oe_needs_select: assert property (p_oe_needs_select) else $error("enable without select");
  a_oe_cause: assert property (p_oe_cause) else $error("enable without link event");
  a_oe_hold: assert property (p_oe_hold) else $error("enable dropped without cause");
  a_fall_needs_link: assert property (p_fall_needs_link) else $error("bit without clock");
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  a_deselect_release: assert property (p_deselect_release) else $error("late release");
endmodule // ew_top_monitor

bind ew_top ew_top_monitor #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_ew_top_monitor (
  .clock             (clock),
  .reset             (reset),
  .serial_clock      (serial_clock),
  .device_select     (device_select),
  .serial_in         (serial_in),
  .word_width_select (word_width_select),
  .serial_out        (serial_out),
  .serial_out_oe     (serial_out_oe)
);

// ===== verif/ew_host.sv
`timescale 1ns/100ps
// ************************************************************
// Host controller that clocks frames into the device.
// ************************************************************
module ew_host (
  // Link pins driven by the host
  output logic      serial_clock,
  output logic      device_select,
  output logic      serial_in,
  // Device output and its enable
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic      last = 1'b0;
  // A released pin reads as the inverse of its last level, never as valid data.
  wire logic pin  = serial_out_oe ? serial_out : ~last;

  initial begin
    serial_clock  = 1'b0;
    device_select = 1'b0;
    serial_in     = 1'b0;
  end

  task automatic select(input logic v);
    device_select = v;
    if (!v) begin
      serial_in = ~serial_in;
      #300;
    end
  endtask

  task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] got);
    got = '0;
    #1.3;
    select(1'b1);
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = bits[i];
      #40;
      serial_clock = 1'b1;
      #39;
      got = {got[62:0], pin};
      last = pin;
      #1;
      serial_clock = 1'b0;
    end
    select(1'b0);
  endtask
endmodule // ew_host

// ===== verif/ew_top_tb.sv
`timescale 1ns/100ps
module ew_top_tb
  import ew_pkg::*;
;
  localparam int WCYC = 1000;

  logic        clock             = 1'b0;
  logic        reset             = 1'b1;
  logic        word_width_select = 1'b1;
  wire logic   serial_clock;
  wire logic   device_select;
  wire logic   serial_in;
  wire logic   serial_out;
  wire logic   serial_out_oe;
  int          num_errors        = 0;
  int          checks_done       = 0;
  int          seed              = 32'h63c7c09d;
  logic [63:0] got;
  logic [7:0]  a;
  logic [7:0]  nxt;
  logic [15:0] d;
  logic [15:0] model [int];

  always #2 clock = ~clock;

  ew_top #(.WRITE_CYCLES_P(WCYC)) u_ew_top (
    .clock             (clock),
    .reset             (reset),
    .serial_clock      (serial_clock),
    .device_select     (device_select),
    .serial_in         (serial_in),
    .word_width_select (word_width_select),
    .serial_out        (serial_out),
    .serial_out_oe     (serial_out_oe)
  );

  ew_host u_ew_host (
    .serial_clock  (serial_clock),
    .device_select (device_select),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask

  // Sends start bit, opcode, address in the current width, then nd trailing bits.
  task automatic send(input logic [1:0] op, input logic [8:0] adr, input logic [15:0] dat,
                      input int nd);
    logic [63:0] bits;
    int          len;
    len  = word_width_select ? 11 : 12;
    bits = word_width_select ? {53'h0, 1'b1, op, adr[7:0]} : {52'h0, 1'b1, op, adr};
    bits = (bits << nd) | {48'h0, dat};
    @(negedge clock);
    u_ew_host.frame(bits, len + nd, got);
  endtask

  task automatic wait_ready(input logic busy);
    int n;
    n = 0;
    u_ew_host.select(1'b1);
    repeat (8) @(negedge clock);
    check({serial_out_oe, serial_out}, {busy, 1'b0}, "busy status");
    while (busy && serial_out !== 1'b1 && n < WCYC + 50) begin
      @(negedge clock);
      n++;
    end
    if (busy) check(serial_out_oe & serial_out, 1'b1, "ready status");
    u_ew_host.select(1'b0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    send(OP_SPECIAL, {1'b0, SUB_EWEN, 6'h00}, 16'h0, 0);
    for (int it = 0; it < 6; it++) begin
      a = (it < 2) ? {8{it[0]}} : 8'($random(seed));
      d = 16'($random(seed));
      nxt = a + 8'h01;
      model[a] = d;
      send(OP_WRITE, {1'b0, a}, d, 16);
      wait_ready(1'b1);
      send(OP_READ, {1'b0, a}, 16'h0, 32);
      check(got[32], 1'b0, "lead bit");
      check(got[31:16], d, "word read");
      if (model.exists(nxt)) check(got[15:0], model[nxt], "next word");
      @(negedge clock);
      word_width_select = 1'b0;
      send(OP_READ, {a, 1'b0}, 16'h0, 16);
      check(got[16], 1'b0, "lead bit x8");
      check(got[15:0], {d[7:0], d[15:8]}, "byte pair");
      d[15:8] = 8'($random(seed));
      send(OP_WRITE, {a, 1'b1}, {8'h00, d[15:8]}, 8);
      wait_ready(1'b1);
      @(negedge clock);
      word_width_select = 1'b1;
      model[a] = d;
      send(OP_READ, {1'b0, a}, 16'h0, 16);
      check(got[15:0], d, "byte into word");
      $display("iteration %0d done", it);
    end
    send(OP_ERASE, {1'b0, a}, 16'h0, 0);
    wait_ready(1'b1);
    u_ew_host.frame({59'h0, 1'b1, OP_READ, 2'b10}, 5, got);
    send(OP_READ, {1'b0, a}, 16'h0, 16);
    check(got[15:0], 16'hffff, "erase then abort");
    $display("erase and abort done");
    send(OP_SPECIAL, {1'b0, SUB_EWDS, 6'h00}, 16'h0, 0);
    send(OP_WRITE, {1'b0, a}, d, 16);
    wait_ready(1'b0);
    send(OP_READ, {1'b0, a}, 16'h0, 16);
    check(got[15:0], 16'hffff, "write while disabled");
    $display("disable done");
    report_and_stop();
  end
endmodule // ew_top_tb
